// File: logic/ast_defines.svh
`ifndef AST_DEFINES_SVH
`define AST_DEFINES_SVH

// Register byte addresses
`define AST_ADDR_MODE 5'h00
`define AST_ADDR_STAT 5'h04
`define AST_ADDR_TXH 5'h08
`define AST_ADDR_RXH 5'h0C
`define AST_ADDR_BRG 5'h10

// Mode register fields
`define AST_M_ENABLE 15
`define AST_M_IRMODE 12
`define AST_M_RTSSIMPLEX 11
`define AST_M_USAGE_HI 9
`define AST_M_USAGE_LO 8
`define AST_M_LOOPBACK 6
`define AST_M_AUTOBAUD 5
`define AST_M_HIGHSPEED 3
`define AST_M_PDS_HI 2
`define AST_M_PDS_LO 1
`define AST_M_TWOSTOP 0
`define AST_MODE_WMASK 16'hDB6F

// Status register fields
`define AST_S_TXSEL1 15
`define AST_S_TXSEL0 13
`define AST_S_BREAK 11
`define AST_S_TXEN 10
`define AST_S_TXFULL 9
`define AST_S_TXIDLE 8
`define AST_S_RXSEL_HI 7
`define AST_S_RXSEL_LO 6
`define AST_S_ADDRDET 5
`define AST_S_RXIDLE 4
`define AST_S_PARITY_ERROR_FLAG 3
`define AST_S_FRAMING_ERROR_FLAG 2
`define AST_S_OVERRUN 1
`define AST_S_RXAVAIL 0

// Reset values
`define AST_MODE_RST 16'h0000
`define AST_BRG_RST 16'h0000

// Field encodings
`define AST_PDS_8N 2'h0
`define AST_PDS_8E 2'h1
`define AST_PDS_8O 2'h2
`define AST_PDS_9N 2'h3
`define AST_USE_DATA 2'h0
`define AST_USE_RTS 2'h1
`define AST_USE_HANDSHAKE 2'h2
`define AST_USE_BCLK 2'h3
`define AST_TXSEL_MOVED 2'h0
`define AST_TXSEL_DONE 2'h1
`define AST_TXSEL_EMPTIED 2'h2
`define AST_RXSEL_ANY 2'h0
`define AST_RXSEL_FULL 2'h3

// Oversampling counts
`define AST_OS16_MAX 4'hF
`define AST_OS4_MAX 4'h3
`define AST_OS16_HALF 4'h7
`define AST_OS4_HALF 4'h1

// Frame shapes
`define AST_BREAK_FRAME 16'hE000
`define AST_BREAK_LEN 5'h0E
`define AST_SYNC_EDGES 3'h5
`define AST_AB_SHIFT16 7
`define AST_AB_SHIFT4 5

`endif

// File: logic/ast_pkg.sv
package ast_pkg;
    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ast_bus_req_t;

    typedef struct packed {
        logic serialOut;
        logic serialOutEn;
        logic rtsPin;
        logic rtsPinEn;
    } ast_pin_out_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_BITS = 2'b10
    } ast_rx_state_t;
endpackage

// File: logic/ast_uart.sv
`include "ast_defines.svh"

module ast_fifo2 #(
    parameter int W = 9
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic flush,
    input wire logic push,
    input wire logic pop,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout,
    output logic [1:0] count
);
    logic [W-1:0] mem [0:1];
    logic wp;
    logic rp;
    wire doPush = push && (count != 2'h2);
    wire doPop = pop && (count != 2'h0);
    assign dout = mem[rp];
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wp <= 1'b0;
            rp <= 1'b0;
            count <= 2'h0;
            mem[0] <= '0;
            mem[1] <= '0;
        end else if (ce) begin
            if (flush) begin
                wp <= 1'b0;
                rp <= 1'b0;
                count <= 2'h0;
            end else begin
                if (doPush) begin
                    mem[wp] <= din;
                    wp <= ~wp;
                end
                if (doPop) begin
                    rp <= ~rp;
                end
                count <= count + {1'b0, doPush} - {1'b0, doPop};
            end
        end
    end
endmodule // ast_fifo2

// Operation
// - Free-running 16-bit baud timer, divisor sets period
// - Normal speed: Fcy over 16 times divisor+1
// - High speed: Fcy over 4 times divisor+1
// - Divisor write clears the baud timer
// - Transmit enable write raises transmit interrupt three cycles later
// - Byte goes to empty shifter, shifts every 16th or 4th baud tick
// - Data preloaded while transmit disabled starts at enable
// - Nine-bit mode: whole-word writes move nine bits
// - Send-break drops next character, sends break instead
// - Receive interrupt per receive interrupt selection
// - Overrun flag set by hardware, cleared by software
// - Reading receive holding pops with own error flags
// - Two-entry queues for transmit and receive
// - 8 or 9 bits, parity options, 1-2 stops
// - Nine-bit address detection on ninth bit one
// - Detect parity, framing and overrun errors
// - Loopback routes transmit output into receiver
// - Auto-baud detection, break and sync sending
// - Handshake pins for simplex and flow control
// - Infrared clock output only in 16x mode
// - Usage 11 drives 16x baud clock on RTS
// - Parity select: 11 9N, 10 8O, 01 8E, 00 8N
// - Break is start, twelve zeros, stop; auto-clears
// - Auto-baud measures 55h sync, then self-clears
// - Usage: 00 data, 01 +RTS, 10 both, 11 clock
module ast_uart (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire ast_pkg::ast_bus_req_t busReq,
    output logic [15:0] rdata,
    input wire logic serialIn,
    input wire logic ctsN,
    output ast_pkg::ast_pin_out_t pins,
    output logic txIrq,
    output logic rxIrq
);
    import ast_pkg::*;

    logic [15:0] modeReg;
    logic [15:0] baudDivisor;
    logic [15:0] brgCnt;
    logic [1:0] txIrqSelect;
    logic sendBreak;
    logic transmitEnable;
    logic [1:0] rxIrqSelect;
    logic addrDetect;
    logic overrunFlag;
    logic [1:0] txEnPipe;
    logic txBusy;
    logic txIsBreak;
    logic [15:0] txShift;
    logic [4:0] txLeft;
    logic [3:0] txSub;
    ast_rx_state_t rxState;
    logic [3:0] rxSub;
    logic [3:0] rxCnt;
    logic [10:0] rxShift;
    logic rxDone;
    logic rxPrev;
    logic [2:0] abEdges;
    logic [23:0] abCnt;

    // Decode
    wire wrMode = busReq.wr && (busReq.addr == `AST_ADDR_MODE);
    wire wrStat = busReq.wr && (busReq.addr == `AST_ADDR_STAT);
    wire wrTxh = busReq.wr && (busReq.addr == `AST_ADDR_TXH);
    wire wrBrg = busReq.wr && (busReq.addr == `AST_ADDR_BRG);
    wire rdRxh = busReq.rd && (busReq.addr == `AST_ADDR_RXH);

    wire enabled = modeReg[`AST_M_ENABLE];
    wire highSpeedBaud = modeReg[`AST_M_HIGHSPEED];
    wire autoBaudEnable = modeReg[`AST_M_AUTOBAUD];
    wire [1:0] parityDataSelect = modeReg[`AST_M_PDS_HI:`AST_M_PDS_LO];
    wire [1:0] pinUsageSelect = modeReg[`AST_M_USAGE_HI:`AST_M_USAGE_LO];
    wire nineBit = (parityDataSelect == `AST_PDS_9N);
    wire parityOn = (parityDataSelect == `AST_PDS_8E) || (parityDataSelect == `AST_PDS_8O);
    wire oddParity = (parityDataSelect == `AST_PDS_8O);
    wire extraBit = nineBit || parityOn;

    // Baud timer and oversample phase
    wire baudTick = enabled && (brgCnt == baudDivisor);
    wire [3:0] osMax = highSpeedBaud ? `AST_OS4_MAX : `AST_OS16_MAX;
    wire [3:0] osHalf = highSpeedBaud ? `AST_OS4_HALF : `AST_OS16_HALF;

    // Transmit queue
    logic [8:0] txTop;
    logic [1:0] txCount;
    wire ctsOk = (pinUsageSelect != `AST_USE_HANDSHAKE) || !ctsN;
    wire txLoad = enabled && transmitEnable && !txBusy && (txCount != 2'h0) && ctsOk;
    wire txBitTick = txBusy && baudTick && (txSub == osMax);
    wire txLast = txBitTick && (txLeft == 5'h01);
    wire txFull = (txCount == 2'h2);
    wire txIdle = !txBusy && (txCount == 2'h0);
    wire txAbort = wrStat && transmitEnable && !busReq.wdata[`AST_S_TXEN];

    ast_fifo2 #(.W(9)) txFifo (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .flush(txAbort || !enabled),
        .push(wrTxh),
        .pop(txLoad),
        .din(busReq.wdata[8:0]),
        .dout(txTop),
        .count(txCount)
    );

    // Frame image, lsb first after the start bit
    wire txPar = oddParity ? ~^txTop[7:0] : ^txTop[7:0];
    wire ninthOut = nineBit ? txTop[8] : (parityOn ? txPar : 1'b1);
    wire [15:0] dataFrame = {6'h3F, ninthOut, txTop[7:0], 1'b0};
    wire [4:0] dataLen = 5'h0A + {4'h0, extraBit} + {4'h0, modeReg[`AST_M_TWOSTOP]};
    wire [15:0] frameImage = sendBreak ? `AST_BREAK_FRAME : dataFrame;
    wire [4:0] frameLen = sendBreak ? `AST_BREAK_LEN : dataLen;

    // Receive side
    logic [10:0] rxTop;
    logic [1:0] rxCount;
    wire rxLine = modeReg[`AST_M_LOOPBACK] ? pins.serialOut : serialIn;
    wire [7:0] rxByte = extraBit ? rxShift[8:1] : rxShift[9:2];
    wire rxNinth = extraBit & rxShift[9];
    wire rxExpPar = oddParity ? ~^rxByte : ^rxByte;
    wire rxParErr = parityOn && (rxShift[9] != rxExpPar);
    wire rxFrmErr = !rxShift[10];
    wire addrReject = addrDetect && nineBit && !rxNinth;
    wire rxAccept = rxDone && !addrReject;
    wire rxPush = rxAccept && (rxCount != 2'h2);
    wire rxOverrun = rxAccept && (rxCount == 2'h2);
    wire [10:0] rxEntry = {rxParErr, rxFrmErr, rxNinth, rxByte};

    ast_fifo2 #(.W(11)) rxFifo (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .flush(!enabled),
        .push(rxPush),
        .pop(rdRxh),
        .din(rxEntry),
        .dout(rxTop),
        .count(rxCount)
    );

    // Auto-baud: five falling edges of the sync span eight bit times
    wire rxFall = rxPrev && !rxLine;
    wire abFinish = autoBaudEnable && rxFall && (abEdges == `AST_SYNC_EDGES - 3'h1);
    wire [23:0] abScaled = highSpeedBaud ? (abCnt >> `AST_AB_SHIFT4) : (abCnt >> `AST_AB_SHIFT16);
    wire [15:0] abDivisor = (abScaled[15:0] == 16'h0000) ? 16'h0000 : abScaled[15:0] - 16'h0001;

    // Interrupt causes
    wire txEnRise = txEnPipe[0] && !txEnPipe[1];
    wire txCause =
        (txIrqSelect == `AST_TXSEL_MOVED) ? txLoad :
        (txIrqSelect == `AST_TXSEL_EMPTIED) ? (txLoad && txCount == 2'h1) :
        (txIrqSelect == `AST_TXSEL_DONE) ? (txLast && txCount == 2'h0) : 1'b0;
    wire rxCause = (rxIrqSelect == `AST_RXSEL_FULL) ? (rxPush && rxCount == 2'h1) : rxPush;

    // Pins
    wire bclkLevel = (brgCnt <= (baudDivisor >> 1));
    wire usageRts = (pinUsageSelect == `AST_USE_RTS) || (pinUsageSelect == `AST_USE_HANDSHAKE);
    wire rtsLevel = modeReg[`AST_M_RTSSIMPLEX] ? txIdle : (rxCount == 2'h2);
    wire bclkMode = (pinUsageSelect == `AST_USE_BCLK) && !highSpeedBaud;

    wire [15:0] statusWord = {txIrqSelect[1], 1'b0, txIrqSelect[0], 1'b0, sendBreak,
        transmitEnable, txFull, txIdle, rxIrqSelect, addrDetect, (rxState == RX_IDLE),
        rxTop[10], rxTop[9], overrunFlag, (rxCount != 2'h0)};
    wire [15:0] readMux =
        (busReq.addr == `AST_ADDR_MODE) ? modeReg :
        (busReq.addr == `AST_ADDR_STAT) ? statusWord :
        (busReq.addr == `AST_ADDR_RXH) ? {7'h00, rxTop[8:0]} :
        (busReq.addr == `AST_ADDR_BRG) ? baudDivisor : 16'h0000;

    // Register file
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            modeReg <= `AST_MODE_RST;
            baudDivisor <= `AST_BRG_RST;
            txIrqSelect <= 2'h0;
            sendBreak <= 1'b0;
            transmitEnable <= 1'b0;
            rxIrqSelect <= 2'h0;
            addrDetect <= 1'b0;
            overrunFlag <= 1'b0;
            rdata <= 16'h0000;
        end else if (ce) begin
            if (busReq.rd) begin
                rdata <= readMux;
            end
            if (wrMode) begin
                modeReg <= busReq.wdata & `AST_MODE_WMASK;
            end else if (abFinish) begin
                modeReg[`AST_M_AUTOBAUD] <= 1'b0;
            end
            if (wrBrg) begin
                baudDivisor <= busReq.wdata;
            end else if (abFinish) begin
                baudDivisor <= abDivisor;
            end
            if (wrStat) begin
                txIrqSelect <= {busReq.wdata[`AST_S_TXSEL1], busReq.wdata[`AST_S_TXSEL0]};
                sendBreak <= busReq.wdata[`AST_S_BREAK];
                transmitEnable <= busReq.wdata[`AST_S_TXEN];
                rxIrqSelect <= busReq.wdata[`AST_S_RXSEL_HI:`AST_S_RXSEL_LO];
                addrDetect <= busReq.wdata[`AST_S_ADDRDET];
            end else if (txLast && txIsBreak) begin
                sendBreak <= 1'b0;
            end
            // Hardware set beats a same-cycle software clear
            if (rxOverrun) begin
                overrunFlag <= 1'b1;
            end else if (wrStat && !busReq.wdata[`AST_S_OVERRUN]) begin
                overrunFlag <= 1'b0;
            end
        end
    end

    // Baud timer, cleared on divisor write or auto-baud reload
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            brgCnt <= 16'h0000;
        end else if (ce) begin
            if (wrBrg || abFinish || baudTick || !enabled) begin
                brgCnt <= 16'h0000;
            end else begin
                brgCnt <= brgCnt + 16'h0001;
            end
        end
    end

    // Transmit shifter; phase held clear while idle so a load starts at once
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            txBusy <= 1'b0;
            txIsBreak <= 1'b0;
            txShift <= 16'hFFFF;
            txLeft <= 5'h00;
            txSub <= 4'h0;
        end else if (ce) begin
            if (!transmitEnable || !enabled) begin
                txBusy <= 1'b0;
                txShift <= 16'hFFFF;
                txSub <= 4'h0;
            end else if (txLoad) begin
                txBusy <= 1'b1;
                txIsBreak <= sendBreak;
                txShift <= frameImage;
                txLeft <= frameLen;
                txSub <= 4'h0;
            end else if (txBusy && baudTick) begin
                txSub <= (txSub == osMax) ? 4'h0 : txSub + 4'h1;
                if (txBitTick) begin
                    txShift <= {1'b1, txShift[15:1]};
                    txLeft <= txLeft - 5'h01;
                    txBusy <= !txLast;
                end
            end
        end
    end

    // Receiver: start on low line, confirm at mid start bit, sample centres
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rxState <= RX_IDLE;
            rxSub <= 4'h0;
            rxCnt <= 4'h0;
            rxShift <= 11'h7FF;
            rxDone <= 1'b0;
        end else if (ce) begin
            rxDone <= 1'b0;
            if (!enabled || autoBaudEnable) begin
                rxState <= RX_IDLE;
            end else if (baudTick) begin
                unique case (rxState)
                    RX_IDLE: begin
                        if (!rxLine) begin
                            rxState <= RX_START;
                            rxSub <= 4'h0;
                        end
                    end
                    RX_START: begin
                        if (rxSub == osHalf) begin
                            rxState <= rxLine ? RX_IDLE : RX_BITS;
                            rxSub <= 4'h0;
                            rxCnt <= 4'h9 + {3'h0, extraBit};
                        end else begin
                            rxSub <= rxSub + 4'h1;
                        end
                    end
                    RX_BITS: begin
                        if (rxSub == osMax) begin
                            rxSub <= 4'h0;
                            rxShift <= {rxLine, rxShift[10:1]};
                            rxCnt <= rxCnt - 4'h1;
                            if (rxCnt == 4'h1) begin
                                rxState <= RX_IDLE;
                                rxDone <= 1'b1;
                            end
                        end else begin
                            rxSub <= rxSub + 4'h1;
                        end
                    end
                    default: rxState <= RX_IDLE;
                endcase
            end
        end
    end

    // Auto-baud measurement in system clocks
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rxPrev <= 1'b1;
            abEdges <= 3'h0;
            abCnt <= 24'h000000;
        end else if (ce) begin
            rxPrev <= rxLine;
            if (!autoBaudEnable || abFinish) begin
                abEdges <= 3'h0;
                abCnt <= 24'h000000;
            end else begin
                if (rxFall) begin
                    abEdges <= abEdges + 3'h1;
                end
                if (abEdges != 3'h0) begin
                    abCnt <= abCnt + 24'h000001;
                end
            end
        end
    end

    // Interrupts and pins, registered
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            txEnPipe <= 2'h0;
            txIrq <= 1'b0;
            rxIrq <= 1'b0;
            pins <= '{serialOut: 1'b1, serialOutEn: 1'b0, rtsPin: 1'b1, rtsPinEn: 1'b0};
        end else if (ce) begin
            txEnPipe <= {txEnPipe[0], transmitEnable && enabled};
            txIrq <= txEnRise || txCause;
            rxIrq <= rxCause;
            pins.serialOut <= (txBusy && transmitEnable && enabled) ? txShift[0] : 1'b1;
            pins.serialOutEn <= enabled && transmitEnable;
            pins.rtsPin <= bclkMode ? bclkLevel : rtsLevel;
            pins.rtsPinEn <= enabled && (usageRts || bclkMode);
        end
    end
endmodule // ast_uart

// File: verification/ast_remote.sv
module ast_remote (
    input wire logic clk,
    input wire logic rxLine,
    output logic txLine
);
    timeunit 1ns;
    timeprecision 1ns;
    int per = 16;
    int nb = 9;
    logic [15:0] got[$];
    logic [15:0] w;
    initial txLine = 1'b1;
    // Start on falling edge, then centre samples; bits after start, first in lsb
    initial begin
        forever begin
            @(negedge rxLine);
            repeat (per / 2) @(posedge clk);
            w = 16'h0000;
            if (rxLine == 1'b0) begin
                for (int i = 0; i < nb; i++) begin
                    repeat (per) @(posedge clk);
                    w[i] = rxLine;
                end
                got.push_back(w);
            end
        end
    end
    // Bits already hold data, parity and stop; one idle bit follows
    task automatic send(input logic [15:0] bits, input int n, input int p);
        txLine <= 1'b0;
        repeat (p) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            txLine <= bits[i];
            repeat (p) @(posedge clk);
        end
        txLine <= 1'b1;
        repeat (p) @(posedge clk);
    endtask
endmodule // ast_remote

// File: verification/ast_uart_chk.sv
`include "ast_defines.svh"
module ast_uart_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire ast_pkg::ast_bus_req_t busReq,
    input wire logic [15:0] rdata,
    input wire logic serialIn,
    input wire logic ctsN,
    input wire ast_pkg::ast_pin_out_t pins,
    input wire logic txIrq,
    input wire logic rxIrq
);
    timeunit 1ns;
    timeprecision 1ns;
    import ast_pkg::*;
    logic [15:0] modeSh;
    logic txEnSh;
    wire wrMode = ce && busReq.wr && busReq.addr == `AST_ADDR_MODE;
    wire wrStat = ce && busReq.wr && busReq.addr == `AST_ADDR_STAT;
    wire wrBrg = ce && busReq.wr && busReq.addr == `AST_ADDR_BRG;
    wire rdReq = ce && busReq.rd;
    wire mapped = busReq.addr inside {`AST_ADDR_MODE, `AST_ADDR_STAT, `AST_ADDR_TXH,
        `AST_ADDR_RXH, `AST_ADDR_BRG};
    wire modeOn = modeSh[`AST_M_ENABLE];
    wire outOn = modeOn && txEnSh;
    wire [1:0] usage = modeSh[`AST_M_USAGE_HI:`AST_M_USAGE_LO];
    wire bclkOn = modeOn && usage == `AST_USE_BCLK && !modeSh[`AST_M_HIGHSPEED];
    wire noRts = !modeOn || usage == `AST_USE_DATA;
    // Shadows follow software writes only; self-clearing bits are not used
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            modeSh <= `AST_MODE_RST;
            txEnSh <= 1'b0;
        end else begin
            if (wrMode) modeSh <= busReq.wdata & `AST_MODE_WMASK;
            if (wrStat) txEnSh <= busReq.wdata[`AST_S_TXEN];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_txen_irq;
        wrStat && busReq.wdata[`AST_S_TXEN] && !txEnSh && modeOn |-> ##3 txIrq;
    endproperty
    a_txen_irq: assert property (p_txen_irq) else $error("no txIrq after enable");
    property p_txirq_pulse;
        txIrq |=> !txIrq;
    endproperty
    a_txirq_pulse: assert property (p_txirq_pulse) else $error("txIrq too long");
    property p_rxirq_pulse;
        rxIrq |=> !rxIrq;
    endproperty
    a_rxirq_pulse: assert property (p_rxirq_pulse) else $error("rxIrq too long");
    property p_brg_rd;
        wrBrg ##1 (rdReq && busReq.addr == `AST_ADDR_BRG) |=> rdata == $past(busReq.wdata, 2);
    endproperty
    a_brg_rd: assert property (p_brg_rd) else $error("divisor readback wrong");
    property p_unmapped;
        rdReq && !mapped |=> rdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rd_hold;
        !rdReq |=> $stable(rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("rdata changed without read");
    property p_outen;
        $stable(outOn) |=> pins.serialOutEn == $past(outOn);
    endproperty
    a_outen: assert property (p_outen) else $error("serial enable wrong");
    property p_idle;
        !pins.serialOutEn |-> pins.serialOut;
    endproperty
    a_idle: assert property (p_idle) else $error("released line not high");
    property p_bclk;
        $stable(bclkOn) && bclkOn |=> pins.rtsPinEn;
    endproperty
    a_bclk: assert property (p_bclk) else $error("clock pin not driven");
    property p_no_rts;
        $stable(noRts) && noRts |=> !pins.rtsPinEn;
    endproperty
    a_no_rts: assert property (p_no_rts) else $error("rts pin driven");
    c_txirq: cover property (txIrq);
    c_rxirq: cover property (rxIrq);
    c_bclk: cover property (bclkOn && pins.rtsPinEn);
    c_brg: cover property (wrBrg ##1 rdReq);
endmodule // ast_uart_chk

bind ast_uart ast_uart_chk u_ast_uart_chk (.clk(clk), .nrst(nrst), .ce(ce), .busReq(busReq),
    .rdata(rdata), .serialIn(serialIn), .ctsN(ctsN), .pins(pins), .txIrq(txIrq), .rxIrq(rxIrq));

// File: verification/test_async_serial_transceiver.sv
`include "ast_defines.svh"
module test_async_serial_transceiver;
    timeunit 1ns;
    timeprecision 1ns;
    import ast_pkg::*;
    logic clk;
    logic nrst;
    logic ctsN;
    logic serialIn;
    logic [15:0] rdata;
    logic txIrq;
    logic rxIrq;
    ast_bus_req_t busReq;
    ast_pin_out_t pins;
    int errors;
    int n_tests;
    int rxCnt;
    int seed;
    logic [15:0] v;
    logic [15:0] w;
    logic [15:0] d;
    logic [15:0] a;
    // Released line reads high, as with a pull-up
    wire lineOut = pins.serialOutEn ? pins.serialOut : 1'b1;

    ast_uart u_ast_uart (.clk(clk), .nrst(nrst), .ce(1'b1), .busReq(busReq), .rdata(rdata),
        .serialIn(serialIn), .ctsN(ctsN), .pins(pins), .txIrq(txIrq), .rxIrq(rxIrq));
    ast_remote u_ast_remote (.clk(clk), .rxLine(lineOut), .txLine(serialIn));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rxIrq === 1'b1) rxCnt++;
    end

    task automatic wr(input logic [4:0] ad, input logic [15:0] wd);
        @(posedge clk);
        busReq <= '{ad, wd, 1'b1, 1'b0};
        @(posedge clk);
        busReq.wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] ad, output logic [15:0] rv);
        @(posedge clk);
        busReq <= '{ad, 16'h0000, 1'b0, 1'b1};
        @(posedge clk);
        busReq.rd <= 1'b0;
        #1 rv = rdata;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bounded wait for one frame seen by the far side
    task automatic get(output logic [15:0] fw);
        int k;
        k = 0;
        while (u_ast_remote.got.size() == 0 && k < 3000) begin
            @(posedge clk);
            k++;
        end
        fw = (k < 3000) ? u_ast_remote.got.pop_front() : 16'hDEAD;
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    function automatic logic [15:0] frame(input logic [1:0] pds, input logic [8:0] fd,
        input logic stop);
        logic p;
        p = (pds == `AST_PDS_8O) ? ~^fd[7:0] : ^fd[7:0];
        if (pds == `AST_PDS_9N) return {6'h00, stop, fd};
        if (pds == `AST_PDS_8N) return {7'h00, stop, fd[7:0]};
        return {6'h00, stop, p, fd[7:0]};
    endfunction
    function automatic int nbits(input logic [1:0] pds);
        return (pds == `AST_PDS_8N) ? 9 : 10;
    endfunction

    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        finish_test();
    end

    initial begin
        seed = 32'h56AA7D52;
        busReq = '0;
        ctsN = 1'b0;
        nrst = 1'b0;
        errors = 0;
        n_tests = 0;
        rxCnt = 0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        chk({12'h000, pins}, 16'h000A);
        rd(`AST_ADDR_MODE, v);
        chk(v, `AST_MODE_RST);
        rd(`AST_ADDR_BRG, v);
        chk(v, `AST_BRG_RST);
        rd(`AST_ADDR_STAT, v);
        chk(v, 16'h0110);
        rd(5'h14, v);
        chk(v, 16'h0000);
        d = 16'($random(seed));
        @(posedge clk);
        busReq <= '{`AST_ADDR_BRG, d, 1'b1, 1'b0};
        @(posedge clk);
        busReq <= '{`AST_ADDR_BRG, d, 1'b0, 1'b1};
        @(posedge clk);
        busReq.rd <= 1'b0;
        #1 chk(rdata, d);
        wr(`AST_ADDR_BRG, 16'h0000);
        done("registers");
        // Each pass changes format, speed and divisor together
        for (int i = 0; i < 4; i++) begin
            wr(`AST_ADDR_MODE, {4'h8, 8'h00, i[0], i[1:0], 1'b0});
            wr(`AST_ADDR_BRG, {14'h0000, i[1:0]});
            wr(`AST_ADDR_STAT, 16'h0400);
            repeat (4) @(posedge clk);
            d = 16'($random(seed));
            u_ast_remote.per = (i[0] ? 4 : 16) * (i + 1);
            u_ast_remote.nb = nbits(i[1:0]);
            wr(`AST_ADDR_TXH, {7'h00, d[8:0]});
            get(w);
            chk(w, frame(i[1:0], d[8:0], 1'b1));
            repeat (64) @(posedge clk);
        end
        done("rates");
        wr(`AST_ADDR_BRG, 16'h0000);
        wr(`AST_ADDR_MODE, 16'h8000);
        wr(`AST_ADDR_STAT, 16'h0C00);
        u_ast_remote.per = 16;
        u_ast_remote.nb = 13;
        wr(`AST_ADDR_TXH, 16'($random(seed)) & 16'h00FF);
        wr(`AST_ADDR_TXH, 16'h0055);
        get(w);
        chk(w, 16'h1000);
        u_ast_remote.nb = 9;
        get(w);
        chk(w, 16'h0155);
        rd(`AST_ADDR_STAT, v);
        chk({15'h0000, v[`AST_S_BREAK]}, 16'h0000);
        done("break");
        wr(`AST_ADDR_MODE, 16'h8002);
        wr(`AST_ADDR_STAT, 16'h0400);
        rxCnt = 0;
        a = 16'($random(seed)) & 16'h00FF;
        d = 16'($random(seed)) & 16'h00FF;
        u_ast_remote.send(frame(`AST_PDS_8E, a[8:0], 1'b1), 10, 16);
        u_ast_remote.send(frame(`AST_PDS_8E, d[8:0], 1'b1) ^ 16'h0100, 10, 16);
        u_ast_remote.send(frame(`AST_PDS_8E, 9'h0A5, 1'b1), 10, 16);
        rd(`AST_ADDR_STAT, v);
        chk(v & 16'h000F, 16'h0003);
        rd(`AST_ADDR_RXH, v);
        chk(v & 16'h00FF, a);
        rd(`AST_ADDR_STAT, v);
        chk(v & 16'h000F, 16'h000B);
        rd(`AST_ADDR_RXH, v);
        chk(v & 16'h00FF, d);
        wr(`AST_ADDR_STAT, 16'h0400);
        rd(`AST_ADDR_STAT, v);
        chk(v & 16'h000F, 16'h0000);
        u_ast_remote.send(frame(`AST_PDS_8E, a[8:0], 1'b0), 10, 16);
        rd(`AST_ADDR_STAT, v);
        chk(v & 16'h000F, 16'h0005);
        rd(`AST_ADDR_RXH, v);
        chk(v & 16'h00FF, a);
        chk(16'(rxCnt), 16'h0003);
        done("receive");
        wr(`AST_ADDR_MODE, 16'h8046);
        wr(`AST_ADDR_STAT, 16'h0420);
        wr(`AST_ADDR_TXH, {8'h00, d[7:0]});
        wr(`AST_ADDR_TXH, {8'h01, a[7:0]});
        repeat (500) @(posedge clk);
        rd(`AST_ADDR_RXH, v);
        chk(v, {8'h01, a[7:0]});
        rd(`AST_ADDR_STAT, v);
        chk(v & 16'h0001, 16'h0000);
        done("loopback");
        for (int u = 0; u < 4; u++) begin
            wr(`AST_ADDR_MODE, {6'h20, u[1:0], 8'h00});
            repeat (3) @(posedge clk);
            chk({15'h0000, pins.rtsPinEn}, {15'h0000, u != 0});
        end
        wr(`AST_ADDR_MODE, 16'h8200);
        wr(`AST_ADDR_STAT, 16'h0000);
        u_ast_remote.got.delete();
        @(posedge clk);
        ctsN <= 1'b1;
        wr(`AST_ADDR_TXH, d);
        wr(`AST_ADDR_STAT, 16'h0400);
        repeat (300) @(posedge clk);
        chk(16'(u_ast_remote.got.size()), 16'h0000);
        chk({15'h0000, pins.rtsPin}, 16'h0000);
        ctsN <= 1'b0;
        get(w);
        chk(w, frame(`AST_PDS_8N, d[8:0], 1'b1));
        done("pins");
        finish_test();
    end
endmodule // test_async_serial_transceiver
